/* File: rtl/sdc_cfg.svh */
// Constants for the synthesizer divider configuration logic
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Serial shift register length
`define SDC_SR_W 14
// Field widths
`define SDC_FB_W 9
`define SDC_PD_W 2
`define SDC_TS_W 3
// Field positions inside the shifted word, first bit shifted is bit 13
`define SDC_TS_MSB 13
`define SDC_TS_LSB 11
`define SDC_PD_MSB 10
`define SDC_PD_LSB 9
`define SDC_FB_MSB 8
`define SDC_FB_LSB 0
// Reset values; feedback and post match the pulled-up parallel pins, test select resets to zero
`define SDC_FB_RST 9'h1ff
`define SDC_PD_RST 2'h3
`define SDC_TS_RST 3'h0
// Oscillator multiplier and its result width
`define SDC_VCO_MULT 12'h008
`define SDC_MULT_W 12
// Post-divider phase counter width
`define SDC_DIV_W 4
// Host pin phase length in system clocks
`define SDC_HALF_CYC 4
// Pin synchroniser vector width
`define SDC_SYNC_W 16
// Synchroniser reset pattern: control pins low, pulled-up pins high
`define SDC_SYNC_RST 16'h07ff

`endif

/* File: rtl/sdc_device.sv */
// Synthesizer end: serial and parallel configuration, divider, gating
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module sdc_device
	import sdc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sdc_link_if.dev link,
	output logic [`SDC_FB_W-1:0] o_cfg_feedback,
	output logic [`SDC_PD_W-1:0] o_cfg_post,
	output logic [`SDC_TS_W-1:0] o_cfg_test,
	output logic [`SDC_MULT_W-1:0] o_vco_mult,
	output logic o_out_running
);

	// Output tap of the phase counter for a post code
	function automatic logic div_tap(input sdc_post_t code,
		input logic [`SDC_DIV_W-1:0] cnt);
		logic tap;
		tap = 1'b0;
		unique case (code)
			SDC_DIV1: tap = cnt[0];
			SDC_DIV2: tap = cnt[1];
			SDC_DIV4: tap = cnt[2];
			SDC_DIV8: tap = cnt[3];
		endcase
		return tap;
	endfunction

	// Pin levels after the pull-ups
	logic [`SDC_FB_W-1:0] pin_fb; // Feedback pins as seen
	logic [`SDC_PD_W-1:0] pin_post; // Post pins as seen
	logic [`SDC_SYNC_W-1:0] pin_vec; // All pins into the synchroniser

	// Two-stage pin synchroniser
	logic [`SDC_SYNC_W-1:0] sync_a; // First stage, read only by sync_b
	logic [`SDC_SYNC_W-1:0] sync_b; // Second stage, safe to use

	// Synchronised pin views
	logic s_clk_s; // Serial clock
	logic s_data_s; // Serial data
	logic s_load_s; // Serial load strobe
	logic p_load_s; // Parallel load strobe
	logic oe_s; // Output enable
	logic [`SDC_FB_W-1:0] par_fb_s; // Parallel feedback value
	logic [`SDC_PD_W-1:0] par_post_s; // Parallel post code

	// Serial clock edge detection
	logic s_clk_q; // Serial clock one cycle late
	logic s_clk_rise; // Rising edge seen

	// Shift register and its fields
	logic [`SDC_SR_W-1:0] shift; // Serial shift register
	logic [`SDC_FB_W-1:0] ser_fb; // Feedback field
	logic [`SDC_PD_W-1:0] ser_post; // Post field
	logic [`SDC_TS_W-1:0] ser_test; // Test select field

	// Configuration latches
	logic [`SDC_FB_W-1:0] cfg_fb; // Held feedback value
	sdc_post_t cfg_post; // Held post code
	sdc_test_t cfg_test; // Held test select
	logic [`SDC_FB_W-1:0] next_fb; // Next feedback value
	sdc_post_t next_post; // Next post code
	sdc_test_t next_test; // Next test select

	// Post-divider and output gating
	logic [`SDC_DIV_W-1:0] div_cnt; // Oscillator phase counter
	logic [`SDC_DIV_W-1:0] next_cnt; // Counter one step ahead
	logic div_next; // Divided clock level next cycle
	logic oe_gate; // Enable as applied to the output
	logic next_gate; // Enable for the next output level
	logic next_out; // Next true output level
	logic next_test_out; // Next test pin level

	// Pull-ups: a pin the host does not drive reads as one
	assign pin_fb = link.par_fb_oe ? link.par_fb : {`SDC_FB_W{1'b1}};
	assign pin_post = link.par_post_oe ? link.par_post
		: {`SDC_PD_W{1'b1}};
	assign pin_vec = {link.s_clock, link.s_data, link.s_load,
		link.p_load, link.out_enable, pin_fb, pin_post};

	// Synchroniser, all pins are asynchronous to this clock
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			// Idle pin levels, so open latches keep the pulled-up defaults
			// instead of loading zeros in the first cycles after reset
			sync_a <= `SDC_SYNC_RST;
			sync_b <= `SDC_SYNC_RST;
		end
		else
		begin
			sync_a <= pin_vec;
			sync_b <= sync_a;
		end
	end

	// Split the synchronised vector
	assign s_clk_s = sync_b[15];
	assign s_data_s = sync_b[14];
	assign s_load_s = sync_b[13];
	assign p_load_s = sync_b[12];
	assign oe_s = sync_b[11];
	assign par_fb_s = sync_b[10:2];
	assign par_post_s = sync_b[1:0];

	// Edge detect works on the second stage only
	assign s_clk_rise = s_clk_s & ~s_clk_q;

	// Serial clock history
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			s_clk_q <= 1'b0;
		else
			s_clk_q <= s_clk_s;
	end

	// Shift register, first bit in ends up in the top position
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			shift <= {`SDC_SR_W{1'b0}};
		else if (s_clk_rise)
			shift <= {shift[`SDC_SR_W-2:0], s_data_s};
	end

	// Field split of the shifted word
	assign ser_test = shift[`SDC_TS_MSB:`SDC_TS_LSB];
	assign ser_post = shift[`SDC_PD_MSB:`SDC_PD_LSB];
	assign ser_fb = shift[`SDC_FB_MSB:`SDC_FB_LSB];

	// Latch behaviour modelled as flops that follow while open.
	// A low parallel strobe is checked first so it overrides serial.
	assign next_fb = !p_load_s ? par_fb_s
		: s_load_s ? ser_fb
		: cfg_fb;
	assign next_post = !p_load_s ? sdc_post_t'(par_post_s)
		: s_load_s ? sdc_post_t'(ser_post)
		: cfg_post;
	// Test select only exists in the serial stream
	assign next_test = s_load_s ? sdc_test_t'(ser_test)
		: cfg_test;

	// Configuration latches
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			cfg_fb <= `SDC_FB_RST;
			cfg_post <= sdc_post_t'(`SDC_PD_RST);
			cfg_test <= sdc_test_t'(`SDC_TS_RST);
		end
		else
		begin
			cfg_fb <= next_fb;
			cfg_post <= next_post;
			cfg_test <= next_test;
		end
	end

	// Each system clock stands for half an oscillator period here, so
	// counter bit k toggles at the oscillator rate divided by 2**k.
	// Every tap is then a square wave with 50% duty.
	assign next_cnt = div_cnt + `SDC_DIV_W'(1);
	assign div_next = div_tap(cfg_post, next_cnt);

	// Enable is only taken while the divided clock is low next cycle,
	// so a high phase is never cut short or started late.
	assign next_gate = div_next ? oe_gate : oe_s;
	assign next_out = next_gate & div_next;

	// Test pin multiplexer
	always_comb
	begin
		next_test_out = 1'b0;
		unique case (cfg_test)
			SDC_TST_LOW: next_test_out = 1'b0;
			SDC_TST_SHIFT: next_test_out = shift[`SDC_SR_W-1];
			SDC_TST_VCO: next_test_out = next_cnt[0];
			SDC_TST_DIV: next_test_out = div_next;
			SDC_TST_GATE: next_test_out = next_gate;
			SDC_TST_FB0: next_test_out = cfg_fb[0];
			SDC_TST_LOAD: next_test_out = s_load_s;
			SDC_TST_HIGH: next_test_out = 1'b1;
		endcase
	end

	// Divider counter and gated differential output.
	// Changing the post code mid-run may give one odd phase; the
	// enable should be low while reprogramming.
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			div_cnt <= {`SDC_DIV_W{1'b0}};
			oe_gate <= 1'b0;
			link.diff_clock_out_p <= 1'b0;
			link.diff_clock_out_n <= 1'b1;
			link.test_out <= 1'b0;
		end
		else
		begin
			div_cnt <= next_cnt;
			oe_gate <= next_gate;
			link.diff_clock_out_p <= next_out;
			link.diff_clock_out_n <= ~next_out;
			link.test_out <= next_test_out;
		end
	end

	// User-side status, registered
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_cfg_feedback <= `SDC_FB_RST;
			o_cfg_post <= `SDC_PD_RST;
			o_cfg_test <= `SDC_TS_RST;
			o_vco_mult <= `SDC_MULT_W'(0);
			o_out_running <= 1'b0;
		end
		else
		begin
			o_cfg_feedback <= cfg_fb;
			o_cfg_post <= cfg_post;
			o_cfg_test <= cfg_test;
			// Multiplier of the reference frequency
			o_vco_mult <= `SDC_VCO_MULT * `SDC_MULT_W'(cfg_fb);
			o_out_running <= next_gate;
		end
	end

endmodule

/* File: rtl/sdc_host.sv */
// Host end: drives the serial and parallel programming pins
`timescale 1ns/1ps
`include "sdc_cfg.svh"

module sdc_host
	import sdc_pkg::*;
#(
	parameter int HALF = `SDC_HALF_CYC
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	sdc_link_if.host link,
	input wire logic i_power_good,
	input wire logic i_out_enable,
	input wire logic i_ser_start,
	input wire logic [`SDC_SR_W-1:0] i_ser_word,
	input wire logic i_par_start,
	input wire logic [`SDC_FB_W-1:0] i_par_fb,
	input wire logic [`SDC_PD_W-1:0] i_par_post,
	input wire logic i_par_release,
	output logic o_busy,
	output logic o_done,
	output logic o_clock_seen,
	output logic o_test_seen
);

	sdc_host_st_t state; // Sequencer state
	logic [7:0] timer; // Cycles left in this phase
	logic [3:0] bits_left; // Bits still to clock after this one
	logic [`SDC_SR_W-1:0] word; // Word being shifted, top bit first
	logic [1:0] clk_sync; // Device clock output synchroniser
	logic [1:0] tst_sync; // Device test output synchroniser
	logic phase_end; // Current phase has run out

	assign phase_end = (timer == 8'h00);

	// Device outputs pass two flops before use
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			clk_sync <= 2'h0;
			tst_sync <= 2'h0;
		end
		else
		begin
			clk_sync <= {clk_sync[0], link.diff_clock_out_p};
			tst_sync <= {tst_sync[0], link.test_out};
		end
	end

	// Pin sequencer
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			state <= SDC_H_IDLE;
			timer <= 8'h00;
			bits_left <= 4'h0;
			word <= {`SDC_SR_W{1'b0}};
			link.s_clock <= 1'b0;
			link.s_data <= 1'b0;
			link.s_load <= 1'b0;
			link.p_load <= 1'b0;
			link.par_fb <= {`SDC_FB_W{1'b1}};
			link.par_fb_oe <= 1'b0;
			link.par_post <= {`SDC_PD_W{1'b1}};
			link.par_post_oe <= 1'b0;
			link.out_enable <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			link.out_enable <= i_out_enable;
			o_done <= 1'b0;
			if (state != SDC_H_IDLE)
				timer <= timer - 8'h01;
			unique case (state)
				SDC_H_IDLE:
				begin
					// Strobe stays low until supply is reported good
					link.p_load <= i_power_good;
					o_busy <= 1'b0;
					if (i_par_release)
					begin
						link.par_fb_oe <= 1'b0;
						link.par_post_oe <= 1'b0;
					end
					if (i_ser_start)
					begin
						word <= i_ser_word;
						link.s_data <= i_ser_word[`SDC_SR_W-1];
						bits_left <= 4'(`SDC_SR_W - 1);
						timer <= 8'(HALF - 1);
						o_busy <= 1'b1;
						state <= SDC_H_SER_LO;
					end
					else if (i_par_start && i_power_good)
					begin
						// Open the latches with the new value on the pins
						link.par_fb <= i_par_fb;
						link.par_post <= i_par_post;
						link.par_fb_oe <= 1'b1;
						link.par_post_oe <= 1'b1;
						link.p_load <= 1'b0;
						timer <= 8'(2 * HALF - 1);
						o_busy <= 1'b1;
						state <= SDC_H_PAR_OPEN;
					end
				end
				SDC_H_SER_LO:
					if (phase_end)
					begin
						link.s_clock <= 1'b1;
						timer <= 8'(HALF - 1);
						state <= SDC_H_SER_HI;
					end
				SDC_H_SER_HI:
					if (phase_end)
					begin
						link.s_clock <= 1'b0;
						timer <= 8'(HALF - 1);
						if (bits_left == 4'h0)
						begin
							link.s_load <= 1'b1;
							state <= SDC_H_SER_LOAD;
						end
						else
						begin
							bits_left <= bits_left - 4'h1;
							word <= {word[`SDC_SR_W-2:0], 1'b0};
							link.s_data <= word[`SDC_SR_W-2];
							state <= SDC_H_SER_LO;
						end
					end
				SDC_H_SER_LOAD:
					if (phase_end)
					begin
						link.s_load <= 1'b0;
						o_done <= 1'b1;
						state <= SDC_H_IDLE;
					end
				SDC_H_PAR_OPEN:
					if (phase_end)
					begin
						// Pins stay driven across and after the rise
						link.p_load <= 1'b1;
						o_done <= 1'b1;
						state <= SDC_H_IDLE;
					end
				default:
					state <= SDC_H_IDLE;
			endcase
		end
	end

	// Registered views of the device outputs
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
		begin
			o_clock_seen <= 1'b0;
			o_test_seen <= 1'b0;
		end
		else
		begin
			o_clock_seen <= clk_sync[1];
			o_test_seen <= tst_sync[1];
		end
	end

endmodule

/* File: rtl/sdc_link_if.sv */
// Pin bundle between the configuration host and the synthesizer
`timescale 1ns/1ps
interface sdc_link_if;
	logic s_clock; // Serial configuration clock
	logic s_data; // Serial configuration data
	logic s_load; // Serial load strobe
	logic p_load; // Parallel load strobe
	logic [8:0] par_fb; // Parallel feedback divider value
	logic par_fb_oe; // Host drives the feedback pins
	logic [1:0] par_post; // Parallel post-divider code
	logic par_post_oe; // Host drives the post-divider pins
	logic out_enable; // Output enable pin
	logic diff_clock_out_p; // True clock output
	logic diff_clock_out_n; // Complement clock output
	logic test_out; // Test output

	modport host (
		output s_clock, s_data, s_load, p_load,
		output par_fb, par_fb_oe, par_post, par_post_oe, out_enable,
		input diff_clock_out_p, diff_clock_out_n, test_out
	);

	modport dev (
		input s_clock, s_data, s_load, p_load,
		input par_fb, par_fb_oe, par_post, par_post_oe, out_enable,
		output diff_clock_out_p, diff_clock_out_n, test_out
	);
endinterface

/* File: rtl/sdc_pkg.sv */
// Types shared by both ends of the synthesizer configuration link
package sdc_pkg;

	// Post-divider codes
	typedef enum logic [1:0] {
		SDC_DIV2 = 2'b00,
		SDC_DIV4 = 2'b01,
		SDC_DIV8 = 2'b10,
		SDC_DIV1 = 2'b11
	} sdc_post_t;

	// Test output node selection
	typedef enum logic [2:0] {
		SDC_TST_LOW = 3'b000,
		SDC_TST_SHIFT = 3'b001,
		SDC_TST_VCO = 3'b010,
		SDC_TST_DIV = 3'b011,
		SDC_TST_GATE = 3'b100,
		SDC_TST_FB0 = 3'b101,
		SDC_TST_LOAD = 3'b110,
		SDC_TST_HIGH = 3'b111
	} sdc_test_t;

	// Host sequencer states
	typedef enum logic [2:0] {
		SDC_H_IDLE = 3'b000,
		SDC_H_SER_LO = 3'b001,
		SDC_H_SER_HI = 3'b010,
		SDC_H_SER_LOAD = 3'b011,
		SDC_H_PAR_OPEN = 3'b100
	} sdc_host_st_t;

endpackage

/* File: verification/sdc_link_asserts.sv */
// Pin-level checker for the host/synthesizer configuration link
`timescale 1ns/1ps
module sdc_link_asserts (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic s_clock,
	input wire logic s_data,
	input wire logic s_load,
	input wire logic p_load,
	input wire logic [8:0] par_fb,
	input wire logic [1:0] par_post,
	input wire logic out_enable,
	input wire logic diff_clock_out_p,
	input wire logic diff_clock_out_n,
	input wire logic test_out
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	logic [4:0] off_cnt; // Cycles since enable pin went low, saturating

	// Twenty cycles covers sync, a full high phase and the register
	always_ff @(posedge i_clk_sys)
		if (i_rst || out_enable)
			off_cnt <= 5'h00;
		else if (off_cnt != 5'h1f)
			off_cnt <= off_cnt + 5'h01;

	a_out_complement: assert property (
		diff_clock_out_n == !diff_clock_out_p)
		else $error("output pair not complementary");
	a_reset_idle: assert property (
		$fell(i_rst) |-> !diff_clock_out_p && !test_out && !p_load)
		else $error("pins not idle after reset");
	a_stop_disabled: assert property (
		off_cnt >= 5'h14 |-> !diff_clock_out_p)
		else $error("output runs while disabled");
	a_sclk_high_len: assert property (
		$rose(s_clock) |-> s_clock [*4] ##1 !s_clock)
		else $error("serial clock high phase wrong");
	a_sdata_stable: assert property (
		$rose(s_clock) |-> $past(s_data, 3) == s_data
			##1 $stable(s_data) [*3])
		else $error("serial data moved near clock rise");
	a_load_quiet: assert property (
		s_load |-> !s_clock)
		else $error("serial clock high during load");
	a_load_fall: assert property (
		$fell(s_load) |-> $past(s_load, 4) && !$past(s_clock, 3))
		else $error("serial load strobe too short");
	a_pload_setup: assert property (
		$rose(p_load) |-> par_fb == $past(par_fb, 3)
			&& par_post == $past(par_post, 3))
		else $error("parallel pins moved before strobe");
endmodule

/* File: verification/test_synth_divider_config_logic.sv */
// Self-checking bench joining host and synthesizer ends
`timescale 1ns/1ps
module test_synth_divider_config_logic import sdc_pkg::*;;
	logic i_clk_sys, i_rst, power_good, out_en; // Clock, reset, levels
	logic ser_start, par_start, par_rel; // Host request pulses
	logic [13:0] ser_word; // Serial word to shift
	logic [8:0] par_fb, cfg_fb; // Parallel value, held feedback
	logic [1:0] par_post, cfg_post; // Parallel code, held code
	logic [2:0] cfg_test; // Held test select
	logic [11:0] vco; // Oscillator multiplier
	logic busy, done, clock_seen, test_seen, running; // Observed outputs
	int num_errors, n_tests; // Mismatch and comparison counts
	sdc_post_t codes [4] = '{SDC_DIV2, SDC_DIV4, SDC_DIV8, SDC_DIV1};
	int pers [4] = '{4, 8, 16, 2}; // Output period in cycles per code

	sdc_link_if link();
	sdc_host #(.HALF(4)) sdc_host_i (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .link(link), .i_power_good(power_good),
		.i_out_enable(out_en), .i_ser_start(ser_start),
		.i_ser_word(ser_word), .i_par_start(par_start), .i_par_fb(par_fb),
		.i_par_post(par_post), .i_par_release(par_rel), .o_busy(busy),
		.o_done(done), .o_clock_seen(clock_seen), .o_test_seen(test_seen));
	sdc_device sdc_device_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.link(link), .o_cfg_feedback(cfg_fb), .o_cfg_post(cfg_post),
		.o_cfg_test(cfg_test), .o_vco_mult(vco), .o_out_running(running));
	sdc_link_asserts sdc_link_asserts_i (.i_clk_sys(i_clk_sys),
		.i_rst(i_rst), .s_clock(link.s_clock), .s_data(link.s_data),
		.s_load(link.s_load), .p_load(link.p_load), .par_fb(link.par_fb),
		.par_post(link.par_post), .out_enable(link.out_enable),
		.diff_clock_out_p(link.diff_clock_out_p),
		.diff_clock_out_n(link.diff_clock_out_n), .test_out(link.test_out));

	// 200 MHz system clock
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	// Compare and count
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	// Counts, verdict, end of run
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Bounded wait for the host's done pulse, then pipeline settling
	task automatic wait_done;
		int k;
		k = 0;
		while (done !== 1'b1 && k < 400)
		begin
			@(negedge i_clk_sys);
			k++;
		end
		if (k == 400)
		begin
			num_errors++;
			print_verdict;
		end
		else
			repeat (8) @(negedge i_clk_sys);
	endtask

	// One serial word through the three-wire path
	task automatic ser_load(input logic [13:0] w);
		@(negedge i_clk_sys);
		ser_start = 1'b1;
		ser_word = w;
		@(negedge i_clk_sys);
		ser_start = 1'b0;
		wait_done;
	endtask

	// Length of the current run of one level, capped so it cannot hang
	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (clock_seen === lvl && n < 40)
		begin
			@(negedge i_clk_sys);
			n++;
		end
	endtask

	// Partial runs skipped first: a code change may leave one odd phase
	task automatic measure(input int per);
		int h, l;
		run_len(1'b1, h);
		run_len(1'b0, l);
		run_len(1'b1, h);
		run_len(1'b0, l);
		check(12'(h), 12'(per / 2));
		check(12'(h + l), 12'(per));
	endtask

	// Main sequence
	initial
	begin
		i_rst = 1'b1;
		{power_good, out_en, ser_start, par_start, par_rel} = 5'h00;
		ser_word = 14'h0000;
		par_fb = 9'h000;
		par_post = 2'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (6) @(negedge i_clk_sys);
		i_rst = 1'b0;
		// Open latches must keep the defaults right after reset
		repeat (2) @(negedge i_clk_sys);
		check(12'(cfg_fb), 12'h1ff);
		check(12'(cfg_post), 12'h003);
		repeat (6) @(negedge i_clk_sys);
		// Undriven pins, strobe low: pulled-up defaults
		check(12'(cfg_fb), 12'h1ff);
		check(12'(cfg_post), 12'h003);
		check(vco, 12'hff8);
		// Parallel request before power is valid is ignored
		par_start = 1'b1;
		par_fb = 9'h012;
		par_post = 2'h0;
		@(negedge i_clk_sys);
		par_start = 1'b0;
		repeat (8) @(negedge i_clk_sys);
		check(12'(busy), 12'h000);
		check(12'(cfg_fb), 12'h1ff);
		// Serial word while parallel open: dividers refused, test taken
		ser_load({3'b111, 2'b00, 9'h0a5});
		check(12'(cfg_fb), 12'h1ff);
		check(12'(cfg_post), 12'h003);
		check(12'(cfg_test), 12'h007);
		check(12'(test_seen), 12'h001);
		// Parallel capture on strobe rise
		power_good = 1'b1;
		@(negedge i_clk_sys);
		par_start = 1'b1;
		@(negedge i_clk_sys);
		par_start = 1'b0;
		wait_done;
		check(12'(cfg_fb), 12'h012);
		check(12'(cfg_post), 12'h000);
		check(vco, 12'h090);
		// Released pins float high; closed latches hold
		par_rel = 1'b1;
		@(negedge i_clk_sys);
		par_rel = 1'b0;
		repeat (8) @(negedge i_clk_sys);
		check(12'(cfg_fb), 12'h012);
		// Full serial load with the parallel strobe closed
		ser_load({3'b101, 2'b01, 9'h155});
		check(12'(cfg_fb), 12'h155);
		check(12'(cfg_post), 12'h001);
		check(12'(cfg_test), 12'h005);
		check(12'(test_seen), 12'h001);
		check(vco, 12'haa8);
		// Every post-divider code with the output running
		out_en = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			ser_load({3'b000, codes[i], 9'h0f0});
			measure(pers[i]);
		end
		check(12'(running), 12'h001);
		check(12'(test_seen), 12'h000);
		// Disabled output parks low
		out_en = 1'b0;
		repeat (24) @(negedge i_clk_sys);
		check(12'(running), 12'h000);
		check(12'(clock_seen), 12'h000);
		// Applied enable on the test pin, off then on
		ser_load({3'b100, 2'b11, 9'h0f0});
		check(12'(test_seen), 12'h000);
		out_en = 1'b1;
		repeat (24) @(negedge i_clk_sys);
		check(12'(running), 12'h001);
		check(12'(test_seen), 12'h001);
		print_verdict;
	end
endmodule
